// *** rtl/drt_cfg.svh ***
`ifndef DRT_CFG_SVH
`define DRT_CFG_SVH

// register byte offsets on the wishbone bus
`define DRT_OFF_CTRL      8'h00
`define DRT_OFF_CNT_LO    8'h04
`define DRT_OFF_CNT_HI    8'h08
`define DRT_OFF_RLD_LO    8'h0c
`define DRT_OFF_RLD_HI    8'h10
`define DRT_OFF_CKCTL     8'h14
`define DRT_OFF_EIE       8'h18
`define DRT_OFF_IRQ_STS   8'h1c
`define DRT_OFF_IRQ_MSK   8'h20

// timer_control_reg fields
`define DRT_CTRL_TFH      7
`define DRT_CTRL_TFL      6
`define DRT_CTRL_LOIEN    5
`define DRT_CTRL_SPLIT    3
`define DRT_CTRL_RUN      2
`define DRT_CTRL_XCLK     0
`define DRT_CTRL_RST      8'h00

// clock_control_reg fields
`define DRT_CK_HI_MODE    1
`define DRT_CK_LO_MODE    0

// ext_interrupt_enable_reg field
`define DRT_EIE_TIMER     7

// interrupt status and mask layout
`define DRT_IRQ_LO        0
`define DRT_IRQ_HI        1

`define DRT_BYTE_RST      8'h00
`define DRT_BYTE_ONES     8'hff

// prescaler ratios
`define DRT_SYS_DIV       12
`define DRT_EXT_DIV       8

`endif

// *** rtl/drt_pkg.sv ***
package drt_pkg;

    typedef logic [7:0] drt_byte_t;

    typedef enum logic [1:0] {
        DRT_SRC_DIV12,
        DRT_SRC_EXT8,
        DRT_SRC_SYS
    } drt_clk_src_e;

endpackage : drt_pkg

// *** rtl/drt_tick_gen.sv ***
`timescale 1ns/10ps
`include "drt_cfg.svh"

module drt_tick_gen #(
    parameter int SYS_DIV = `DRT_SYS_DIV,
    parameter int EXT_DIV = `DRT_EXT_DIV
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ext_clk_i,
    output logic      tick_div12_o,
    output logic      tick_ext8_o
);

    localparam int SW = $clog2(SYS_DIV);
    localparam int EW = $clog2(EXT_DIV);

    logic [SW-1:0] sdiv_reg;
    logic [SW-1:0] sdiv_next;
    logic [EW-1:0] ediv_reg;
    logic [EW-1:0] ediv_next;
    logic [2:0]    sync_reg;
    logic [2:0]    sync_next;
    logic          t12_reg;
    logic          t12_next;
    logic          t8_reg;
    logic          t8_next;
    logic          ext_rise;

    ////////////////////////////////////////////////////////////////
    always_comb begin
        // stage 0 feeds only stage 1; edge taken from stages 1 and 2
        sync_next = {sync_reg[1:0], ext_clk_i};
        ext_rise  = sync_reg[1] & ~sync_reg[2];
        t12_next  = (sdiv_reg == SW'(SYS_DIV - 1));
        sdiv_next = t12_next ? '0 : sdiv_reg + SW'(1);
        t8_next   = ext_rise && (ediv_reg == EW'(EXT_DIV - 1));
        // wraps on the ratio, not on the counter width
        ediv_next = !ext_rise ? ediv_reg : (t8_next ? '0 : ediv_reg + EW'(1));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sdiv_reg <= '0;
            ediv_reg <= '0;
            // keeps sampling in reset: a high pin shows no false edge at release
            sync_reg <= sync_next;
            t12_reg  <= 1'b0;
            t8_reg   <= 1'b0;
        end else begin
            sdiv_reg <= sdiv_next;
            ediv_reg <= ediv_next;
            sync_reg <= sync_next;
            t12_reg  <= t12_next;
            t8_reg   <= t8_next;
        end
    end

    assign tick_div12_o = t12_reg;
    assign tick_ext8_o  = t8_reg;

endmodule : drt_tick_gen

// *** rtl/drt_count_byte.sv ***
`timescale 1ns/10ps
`include "drt_cfg.svh"

module drt_count_byte (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              inc_i,
    input  wire logic              load_i,
    input  wire logic              wr_i,
    input  wire drt_pkg::drt_byte_t wr_data_i,
    input  wire drt_pkg::drt_byte_t reload_i,
    output drt_pkg::drt_byte_t     count_o,
    output logic                   all_ones_o
);
    import drt_pkg::*;

    drt_byte_t cnt_reg;
    drt_byte_t cnt_next;

    ////////////////////////////////////////////////////////////////
    always_comb begin
        // software write wins over a tick in the same cycle
        if (wr_i) begin
            cnt_next = wr_data_i;
        end else if (load_i) begin
            cnt_next = reload_i;
        end else if (inc_i) begin
            cnt_next = cnt_reg + 8'h01;
        end else begin
            cnt_next = cnt_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= `DRT_BYTE_RST;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign count_o    = cnt_reg;
    assign all_ones_o = (cnt_reg == `DRT_BYTE_ONES);

endmodule : drt_count_byte

// *** rtl/drt_timer.sv ***
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
`include "drt_cfg.svh"

// Behaviour
// - the count lives in a low byte and a high byte that together form one 16-bit value.
// - with split mode clear the two bytes run as one 16-bit auto-reload timer.
// - the clock is the system clock, the system clock over 12, or a synchronised external clock over 8.
// - in 16-bit mode a roll from 0xffff loads the reload pair in place of 0x0000 and sets the high flag.
// - in 16-bit mode the timer interrupt enable requests an interrupt on every 16-bit overflow.
// - in 16-bit mode with the low interrupt enable also set, each low byte roll also interrupts.
// - with split mode set and no capture the bytes run as two 8-bit auto-reload timers.
// - in split mode each byte reloads from its own reload register on its own overflow.
// - in split mode run control gates only the high byte while the low byte always counts.
// - in split mode each byte picks its clock: mode bit set gives system clock, else external select picks.
// - in split mode the high flag marks a high byte roll and the low flag a low byte roll.
// - in split mode the timer enable interrupts on high overflow, and on either with low enable.
// - overflow flags stay set until software clears them and hardware never clears them.
// - the 16-bit timer, and in split mode the high byte, counts only while run control is 1 and holds its count when it is 0.
// - the low flag is set on every low byte roll in both modes.
// - the control register resets to zero, with bits 4 and 1 reading as zero.
module drt_timer #(
    parameter int AW = 8
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          ext_clk_i,
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [AW-1:0] wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic [31:0]        wb_dat_o,
    output logic               wb_ack_o,
    output drt_pkg::drt_byte_t count_low_byte_o,
    output drt_pkg::drt_byte_t count_high_byte_o,
    output logic               irq_o
);
    import drt_pkg::*;

    ////////////////////////////////////////////////////////////////
    // register state
    logic      tfh_reg;
    logic      tfh_next;
    logic      tfl_reg;
    logic      tfl_next;
    logic      loien_reg;
    logic      loien_next;
    logic      split_reg;
    logic      split_next;
    logic      run_reg;
    logic      run_next;
    logic      xclk_reg;
    logic      xclk_next;
    logic      ckhi_reg;
    logic      ckhi_next;
    logic      cklo_reg;
    logic      cklo_next;
    logic      tien_reg;
    logic      tien_next;
    logic [1:0] sts_reg;
    logic [1:0] sts_next;
    logic [1:0] msk_reg;
    logic [1:0] msk_next;
    drt_byte_t rld_lo_reg;
    drt_byte_t rld_lo_next;
    drt_byte_t rld_hi_reg;
    drt_byte_t rld_hi_next;
    logic      ack_reg;
    logic      ack_next;
    logic [31:0] rdat_reg;
    logic [31:0] rdat_next;

    // datapath nets
    logic      tick12;
    logic      tick8;
    logic      lo_tick;
    logic      hi_tick;
    logic      lo_inc;
    logic      hi_inc;
    logic      lo_load;
    logic      hi_load;
    logic      lo_ones;
    logic      hi_ones;
    logic      set_h;
    logic      set_l;
    drt_byte_t cnt_lo;
    drt_byte_t cnt_hi;

    // bus nets
    logic      req;
    logic      wr;
    logic      wr_b0;
    drt_byte_t wdat;
    drt_byte_t ctrl_rd;

    ////////////////////////////////////////////////////////////////
    // clock source decoding, used by both bytes
    function automatic drt_clk_src_e src_sel(input logic mode, input logic xclk);
        if (mode) begin
            src_sel = DRT_SRC_SYS;
        end else if (xclk) begin
            src_sel = DRT_SRC_EXT8;
        end else begin
            src_sel = DRT_SRC_DIV12;
        end
    endfunction : src_sel

    function automatic logic src_tick(input drt_clk_src_e s, input logic t12,
                                      input logic t8);
        case (s)
            DRT_SRC_SYS:   src_tick = 1'b1;
            DRT_SRC_EXT8:  src_tick = t8;
            DRT_SRC_DIV12: src_tick = t12;
            default:       src_tick = 1'b0;
        endcase
    endfunction : src_tick

    function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] off);
        hit = (a == AW'(off));
    endfunction : hit

    ////////////////////////////////////////////////////////////////
    // prescalers: external clock synchronised, both divide as enables
    drt_tick_gen u_tick (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .ext_clk_i    (ext_clk_i),
        .tick_div12_o (tick12),
        .tick_ext8_o  (tick8)
    );

    ////////////////////////////////////////////////////////////////
    // bus decode
    always_comb begin
        req   = wb_cyc_i & wb_stb_i;
        // writes land on the edge that also sees ack high
        wr    = req & wb_we_i & ack_reg;
        wr_b0 = wr & wb_sel_i[0];
        wdat  = wb_dat_i[7:0];
    end

    ////////////////////////////////////////////////////////////////
    // count enables
    always_comb begin
        // 16-bit mode follows the low byte clock selection
        lo_tick = src_tick(src_sel(cklo_reg, xclk_reg), tick12, tick8);
        hi_tick = src_tick(src_sel(ckhi_reg, xclk_reg), tick12, tick8);
        if (split_reg) begin
            lo_inc  = lo_tick;
            lo_load = lo_inc & lo_ones;
            hi_inc  = run_reg & hi_tick;
            hi_load = hi_inc & hi_ones;
            set_l   = lo_load;
            set_h   = hi_load;
        end else begin
            lo_inc  = run_reg & lo_tick;
            hi_inc  = lo_inc & lo_ones;
            lo_load = hi_inc & hi_ones;
            hi_load = lo_load;
            set_l   = lo_inc & lo_ones;
            set_h   = lo_load;
        end
    end

    ////////////////////////////////////////////////////////////////
    // count bytes
    drt_count_byte u_lo (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .inc_i      (lo_inc),
        .load_i     (lo_load),
        .wr_i       (wr_b0 && hit(wb_adr_i, `DRT_OFF_CNT_LO)),
        .wr_data_i  (wdat),
        .reload_i   (rld_lo_reg),
        .count_o    (cnt_lo),
        .all_ones_o (lo_ones)
    );

    drt_count_byte u_hi (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .inc_i      (hi_inc),
        .load_i     (hi_load),
        .wr_i       (wr_b0 && hit(wb_adr_i, `DRT_OFF_CNT_HI)),
        .wr_data_i  (wdat),
        .reload_i   (rld_hi_reg),
        .count_o    (cnt_hi),
        .all_ones_o (hi_ones)
    );

    ////////////////////////////////////////////////////////////////
    // control, clock select, enables and interrupt registers
    always_comb begin
        loien_next  = loien_reg;
        split_next  = split_reg;
        run_next    = run_reg;
        xclk_next   = xclk_reg;
        ckhi_next   = ckhi_reg;
        cklo_next   = cklo_reg;
        tien_next   = tien_reg;
        msk_next    = msk_reg;
        rld_lo_next = rld_lo_reg;
        rld_hi_next = rld_hi_reg;
        tfh_next    = tfh_reg;
        tfl_next    = tfl_reg;
        sts_next    = sts_reg;
        if (wr_b0) begin
            if (hit(wb_adr_i, `DRT_OFF_CTRL)) begin
                tfh_next   = wdat[`DRT_CTRL_TFH];
                tfl_next   = wdat[`DRT_CTRL_TFL];
                loien_next = wdat[`DRT_CTRL_LOIEN];
                split_next = wdat[`DRT_CTRL_SPLIT];
                run_next   = wdat[`DRT_CTRL_RUN];
                xclk_next  = wdat[`DRT_CTRL_XCLK];
            end
            if (hit(wb_adr_i, `DRT_OFF_CKCTL)) begin
                ckhi_next = wdat[`DRT_CK_HI_MODE];
                cklo_next = wdat[`DRT_CK_LO_MODE];
            end
            if (hit(wb_adr_i, `DRT_OFF_EIE)) begin
                tien_next = wdat[`DRT_EIE_TIMER];
            end
            if (hit(wb_adr_i, `DRT_OFF_RLD_LO)) begin
                rld_lo_next = wdat;
            end
            if (hit(wb_adr_i, `DRT_OFF_RLD_HI)) begin
                rld_hi_next = wdat;
            end
            if (hit(wb_adr_i, `DRT_OFF_IRQ_STS)) begin
                sts_next = sts_reg & ~wdat[1:0];
            end
            if (hit(wb_adr_i, `DRT_OFF_IRQ_MSK)) begin
                msk_next = wdat[1:0];
            end
        end
        // a hardware set beats a software clear in the same cycle
        if (set_h) begin
            tfh_next = 1'b1;
            sts_next[`DRT_IRQ_HI] = 1'b1;
        end
        if (set_l) begin
            tfl_next = 1'b1;
            sts_next[`DRT_IRQ_LO] = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tfh_reg    <= 1'b0;
            tfl_reg    <= 1'b0;
            loien_reg  <= 1'b0;
            split_reg  <= 1'b0;
            run_reg    <= 1'b0;
            xclk_reg   <= 1'b0;
            ckhi_reg   <= 1'b0;
            cklo_reg   <= 1'b0;
            tien_reg   <= 1'b0;
            sts_reg    <= 2'h0;
            msk_reg    <= 2'h0;
            rld_lo_reg <= `DRT_BYTE_RST;
            rld_hi_reg <= `DRT_BYTE_RST;
        end else begin
            tfh_reg    <= tfh_next;
            tfl_reg    <= tfl_next;
            loien_reg  <= loien_next;
            split_reg  <= split_next;
            run_reg    <= run_next;
            xclk_reg   <= xclk_next;
            ckhi_reg   <= ckhi_next;
            cklo_reg   <= cklo_next;
            tien_reg   <= tien_next;
            sts_reg    <= sts_next;
            msk_reg    <= msk_next;
            rld_lo_reg <= rld_lo_next;
            rld_hi_reg <= rld_hi_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // bus answer: ack one cycle after the request, read data with it
    always_comb begin
        ctrl_rd = 8'h00;
        ctrl_rd[`DRT_CTRL_TFH]   = tfh_reg;
        ctrl_rd[`DRT_CTRL_TFL]   = tfl_reg;
        ctrl_rd[`DRT_CTRL_LOIEN] = loien_reg;
        ctrl_rd[`DRT_CTRL_SPLIT] = split_reg;
        ctrl_rd[`DRT_CTRL_RUN]   = run_reg;
        ctrl_rd[`DRT_CTRL_XCLK]  = xclk_reg;
        ack_next  = req & ~ack_reg;
        rdat_next = rdat_reg;
        if (req & ~ack_reg) begin
            // unmapped addresses still answer, reading zero
            rdat_next = 32'h0000_0000;
            if (hit(wb_adr_i, `DRT_OFF_CTRL)) begin
                rdat_next[7:0] = ctrl_rd;
            end
            if (hit(wb_adr_i, `DRT_OFF_CNT_LO)) begin
                rdat_next[7:0] = cnt_lo;
            end
            if (hit(wb_adr_i, `DRT_OFF_CNT_HI)) begin
                rdat_next[7:0] = cnt_hi;
            end
            if (hit(wb_adr_i, `DRT_OFF_RLD_LO)) begin
                rdat_next[7:0] = rld_lo_reg;
            end
            if (hit(wb_adr_i, `DRT_OFF_RLD_HI)) begin
                rdat_next[7:0] = rld_hi_reg;
            end
            if (hit(wb_adr_i, `DRT_OFF_CKCTL)) begin
                rdat_next[`DRT_CK_HI_MODE] = ckhi_reg;
                rdat_next[`DRT_CK_LO_MODE] = cklo_reg;
            end
            if (hit(wb_adr_i, `DRT_OFF_EIE)) begin
                rdat_next[`DRT_EIE_TIMER] = tien_reg;
            end
            if (hit(wb_adr_i, `DRT_OFF_IRQ_STS)) begin
                rdat_next[1:0] = sts_reg;
            end
            if (hit(wb_adr_i, `DRT_OFF_IRQ_MSK)) begin
                rdat_next[1:0] = msk_reg;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg  <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end else begin
            ack_reg  <= ack_next;
            rdat_reg <= rdat_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs
    assign wb_ack_o          = ack_reg;
    assign wb_dat_o          = rdat_reg;
    assign count_low_byte_o  = cnt_lo;
    assign count_high_byte_o = cnt_hi;

    // low byte events only count when the low enable is on
    assign irq_o = tien_reg & ((sts_reg[`DRT_IRQ_HI] & msk_reg[`DRT_IRQ_HI]) |
                   (sts_reg[`DRT_IRQ_LO] & msk_reg[`DRT_IRQ_LO] & loien_reg));

endmodule : drt_timer

// *** tb/drt_timer_asserts.sv ***
`timescale 1ns/10ps
`include "drt_cfg.svh"

module drt_timer_asserts #(
    parameter int AW = 8
) (
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic               ext_clk_i,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_we_i,
    input wire logic [AW-1:0]      wb_adr_i,
    input wire logic [3:0]         wb_sel_i,
    input wire logic [31:0]        wb_dat_i,
    input wire logic [31:0]        wb_dat_o,
    input wire logic               wb_ack_o,
    input wire drt_pkg::drt_byte_t count_low_byte_o,
    input wire drt_pkg::drt_byte_t count_high_byte_o,
    input wire logic               irq_o
);
    import drt_pkg::*;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////////////////
    // software writes to a count byte land at the ack edge
    logic wr_lo;
    logic wr_hi;
    logic sw_wr;
    assign sw_wr = wb_ack_o && wb_we_i;
    assign wr_lo = sw_wr && wb_sel_i[0] && (wb_adr_i == `DRT_OFF_CNT_LO);
    assign wr_hi = sw_wr && wb_sel_i[0] && (wb_adr_i == `DRT_OFF_CNT_HI);

    ////////////////////////////////////////////////////////////////////////////////
    AST_ACK_NEXT:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    AST_ACK_PULSE:
        assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_DAT_UPPER:
        assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read data not zero");
    AST_RST_CLEAR:
        assert property ($fell(rst_i) |-> count_low_byte_o == 8'h00
                         && count_high_byte_o == 8'h00 && !irq_o && !wb_ack_o)
        else $error("state not cleared by reset");
    AST_CTRL_RSVD:
        assert property (wb_ack_o && !wb_we_i && wb_adr_i == `DRT_OFF_CTRL
                         |-> wb_dat_o[4] == 1'b0 && wb_dat_o[1] == 1'b0)
        else $error("control unused bits read nonzero");
    // below ff a byte may only hold or step by one
    AST_LO_STEP:
        assert property (!$past(wr_lo) && $past(count_low_byte_o) != 8'hff
                         |-> count_low_byte_o == $past(count_low_byte_o)
                         || count_low_byte_o == $past(count_low_byte_o) + 8'h01)
        else $error("low byte jumped");
    AST_HI_STEP:
        assert property (!$past(wr_hi) && $past(count_high_byte_o) != 8'hff
                         |-> count_high_byte_o == $past(count_high_byte_o)
                         || count_high_byte_o == $past(count_high_byte_o) + 8'h01)
        else $error("high byte jumped");
    AST_IRQ_HOLD:
        assert property ($fell(irq_o) |-> $past(sw_wr))
        else $error("interrupt dropped without software write");
    AST_IRQ_CAUSE:
        assert property ($rose(irq_o) |-> $past(sw_wr)
                         || $past(count_low_byte_o) == 8'hff || $past(count_high_byte_o) == 8'hff
                         || $past(count_low_byte_o, 2) == 8'hff
                         || $past(count_high_byte_o, 2) == 8'hff)
        else $error("interrupt rose without overflow or write");

endmodule : drt_timer_asserts

bind drt_timer drt_timer_asserts #(.AW(AW)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .ext_clk_i(ext_clk_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .count_low_byte_o(count_low_byte_o), .count_high_byte_o(count_high_byte_o),
    .irq_o(irq_o)
);

// *** tb/drt_timer_bench.sv ***
`timescale 1ns/10ps
`include "drt_cfg.svh"

module drt_timer_bench;
    import drt_pkg::*;

    logic        clk_i     = 1'b0;
    logic        rst_i     = 1'b1;
    logic        ext_clk_i = 1'b0;
    logic        ext_ph    = 1'b0;
    logic        wb_cyc_i  = 1'b0;
    logic        wb_stb_i  = 1'b0;
    logic        wb_we_i   = 1'b0;
    logic [7:0]  wb_adr_i  = 8'h00;
    logic [3:0]  wb_sel_i  = 4'h0;
    logic [31:0] wb_dat_i  = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        irq_o;
    drt_byte_t   count_low_byte_o;
    drt_byte_t   count_high_byte_o;
    logic [31:0] rdv;
    drt_byte_t   held;
    int          miscompares = 0;
    int          comparisons = 0;

    drt_timer #(.AW(8)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .ext_clk_i(ext_clk_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .count_low_byte_o(count_low_byte_o), .count_high_byte_o(count_high_byte_o),
        .irq_o(irq_o)
    );

    always #12.5 clk_i = ~clk_i;

    // external oscillator at a quarter of the system clock
    always @(posedge clk_i) begin
        ext_ph <= ~ext_ph;
        if (ext_ph) begin
            ext_clk_i <= ~ext_clk_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // extra edge at the end so the access has landed before anyone looks
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        // no answer time assumed; only the watchdog ends a lost answer
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1);
        rdv = wb_dat_o;
        // ack stands one cycle after the request is taken
        chk(k, 2);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(rdv, exp);
    endtask : rd

    task automatic wait_byte(input logic hi_sel, input drt_byte_t v);
        int k = 0;
        while ((hi_sel ? count_high_byte_o : count_low_byte_o) !== v && k < 400) begin
            @(posedge clk_i);
            k++;
        end
        chk({24'h0, hi_sel ? count_high_byte_o : count_low_byte_o}, {24'h0, v});
    endtask : wait_byte

    // first change may be a partial period, so time the second one
    task automatic meas(input int exp);
        drt_byte_t v;
        int        k;
        v = count_low_byte_o;
        k = 0;
        while (count_low_byte_o === v && k < 100) begin
            @(posedge clk_i);
            k++;
        end
        v = count_low_byte_o;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (count_low_byte_o === v && k < 100);
        chk(k, exp);
    endtask : meas

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(`DRT_OFF_CTRL, 32'h00);
        rd(`DRT_OFF_RLD_HI, 32'h00);
        chk({count_high_byte_o, count_low_byte_o}, 32'h0);
        wr(`DRT_OFF_CTRL, 32'hd2);
        rd(`DRT_OFF_CTRL, 32'hc0);
        wr(`DRT_OFF_CTRL, 32'h00);
        rd(`DRT_OFF_CTRL, 32'h00);
        rd(8'h24, 32'h00);
    endtask : t_reset

    task automatic t_sixteen;
        wr(`DRT_OFF_CKCTL, 32'h01);
        wr(`DRT_OFF_RLD_LO, 32'h12);
        wr(`DRT_OFF_RLD_HI, 32'h34);
        wr(`DRT_OFF_CNT_LO, 32'hfd);
        wr(`DRT_OFF_CNT_HI, 32'hff);
        wr(`DRT_OFF_CTRL, 32'h04);
        wait_byte(1'b1, 8'h34);
        chk({24'h0, count_low_byte_o}, 32'h12);
        rd(`DRT_OFF_CTRL, 32'hc4);
        wr(`DRT_OFF_CTRL, 32'hc0);
        held = count_low_byte_o;
        repeat (20) @(posedge clk_i);
        chk({24'h0, count_low_byte_o}, {24'h0, held});
        rd(`DRT_OFF_CTRL, 32'hc0);
    endtask : t_sixteen

    task automatic t_irq;
        rd(`DRT_OFF_IRQ_STS, 32'h03);
        wr(`DRT_OFF_IRQ_MSK, 32'h02);
        wr(`DRT_OFF_EIE, 32'h80);
        chk({31'h0, irq_o}, 32'h1);
        wr(`DRT_OFF_IRQ_MSK, 32'h00);
        chk({31'h0, irq_o}, 32'h0);
        wr(`DRT_OFF_IRQ_MSK, 32'h03);
        wr(`DRT_OFF_IRQ_STS, 32'h02);
        chk({31'h0, irq_o}, 32'h0);
        wr(`DRT_OFF_CTRL, 32'he0);
        chk({31'h0, irq_o}, 32'h1);
        wr(`DRT_OFF_IRQ_STS, 32'h01);
        chk({31'h0, irq_o}, 32'h0);
        rd(`DRT_OFF_IRQ_STS, 32'h00);
    endtask : t_irq

    task automatic t_split;
        wr(`DRT_OFF_CTRL, 32'h08);
        wr(`DRT_OFF_CKCTL, 32'h03);
        wr(`DRT_OFF_RLD_LO, 32'h50);
        wr(`DRT_OFF_CNT_HI, 32'h10);
        wr(`DRT_OFF_CNT_LO, 32'hfe);
        wait_byte(1'b0, 8'h50);
        chk({24'h0, count_high_byte_o}, 32'h10);
        rd(`DRT_OFF_CTRL, 32'h48);
        chk({31'h0, irq_o}, 32'h0);
        wr(`DRT_OFF_RLD_HI, 32'h77);
        wr(`DRT_OFF_CNT_HI, 32'hfe);
        wr(`DRT_OFF_CTRL, 32'h0c);
        wait_byte(1'b1, 8'h77);
        rd(`DRT_OFF_CTRL, 32'h8c);
        chk({31'h0, irq_o}, 32'h1);
        wr(`DRT_OFF_IRQ_STS, 32'h02);
        chk({31'h0, irq_o}, 32'h0);
        wr(`DRT_OFF_CTRL, 32'h2c);
        chk({31'h0, irq_o}, 32'h1);
        wr(`DRT_OFF_EIE, 32'h00);
    endtask : t_split

    task automatic t_clocks;
        wr(`DRT_OFF_CKCTL, 32'h00);
        wr(`DRT_OFF_CTRL, 32'h04);
        meas(12);
        wr(`DRT_OFF_CTRL, 32'h05);
        meas(32);
        wr(`DRT_OFF_CKCTL, 32'h01);
        meas(1);
    endtask : t_clocks

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (10000) @(posedge clk_i);
        miscompares++;
        tally_and_finish;
    end

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_sixteen;
        t_irq;
        t_split;
        t_clocks;
        // reset again while running at full rate
        rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        tally_and_finish;
    end

endmodule : drt_timer_bench
